// file: core/mtab_defs.svh
// constants for the mac lookup table entry data registers
// assumes a word-indexed register port; byte address is four times the index
// Summary of operation
// - port code: singles 0-2, 011 reserved, pairs/all
// - port field msb selects single or multiple
// - write hi word bits 15:0 hold last address bits
// - read lo word read-only first 32 address bits
// - read words load only on fetch commands
// - valid clears when a fetch bit is written
// - valid set when search finds an entry
// - end flag set when search reaches table end
// - static flag marks entry exempt from aging
// - filter flag marks destination-match discard
// - priority-enable flag reports priority field use
// - priority applies with enable and global setting
// - fetch first rewinds, fetch next advances; clear after
// - write lo word holds first 32 address bits
`ifndef MTAB_DEFS_SVH
`define MTAB_DEFS_SVH
`define MTAB_IDX_CMD      16'h1800
`define MTAB_IDX_WR_LO    16'h1801
`define MTAB_IDX_WR_HI    16'h1802
`define MTAB_IDX_RD_LO    16'h1805
`define MTAB_IDX_RD_HI    16'h1806
`define MTAB_IDX_GCFG     16'h1840
`define MTAB_CMD_FIRST    1
`define MTAB_CMD_NEXT     0
`define MTAB_BIT_VALID    26
`define MTAB_BIT_END      25
`define MTAB_BIT_STATIC   24
`define MTAB_BIT_FILTER   23
`define MTAB_BIT_PRIEN    22
`define MTAB_PRI_LSB      19
`define MTAB_PORT_LSB     16
`define MTAB_PORT_MSB     18
`define MTAB_HI_WR_MASK   32'h07ffffff
`define MTAB_RST_WORD     32'h00000000
`define MTAB_ENTRIES      512
`endif

// file: core/mtab_pkg.sv
// types for the mac lookup table entry data registers
package mtab_pkg;
    typedef struct packed {
        logic        valid;
        logic        age;
        logic        static_e;
        logic        filter;
        logic        pri_en;
        logic [2:0]  pri;
        logic [2:0]  port;
        logic [47:0] mac;
    } mtab_entry_t;
    typedef enum logic [2:0] {
        MTAB_IDLE = 3'b001,
        MTAB_SCAN = 3'b010,
        MTAB_DONE = 3'b100
    } mtab_state_t;
endpackage

// file: core/mtab_mem.sv
// table storage: one write port, registered read port
// assumes one clock; contents undefined until written
`timescale 1ns/1ps
module mtab_mem
    import mtab_pkg::*;
#(
    parameter int DEPTH = 512,
    parameter int AW    = 9
) (
    // clock
    input  wire logic         clk,
    // write port
    input  wire logic         we,
    input  wire logic [AW-1:0] waddr,
    input  wire mtab_entry_t  wdata,
    // read port
    input  wire logic [AW-1:0] raddr,
    output mtab_entry_t       rdata
);
    mtab_entry_t mem [DEPTH];

    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end
endmodule

// file: core/mtab_regs.sv
// mac lookup table entry data registers with table walk engine
// assumes register port strobes are single-cycle and never both high
`timescale 1ns/1ps
`include "mtab_defs.svh"
module mtab_regs
    import mtab_pkg::*;
#(
    parameter int DEPTH = `MTAB_ENTRIES,
    parameter int AW    = 9
) (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // register port
    input  wire logic [15:0] reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic [31:0]      reg_rdata,
    // make-entry path from the command block
    input  wire logic        make_entry,
    input  wire logic [AW-1:0] make_addr,
    // forwarding lookup side
    input  wire logic [AW-1:0] look_addr,
    output logic [2:0]       look_pri,
    output logic             look_pri_use,
    output logic             look_filter,
    output logic [2:0]       look_ports,
    output logic             walk_busy
);
    // egress port mask from the three-bit code
    function automatic logic [2:0] port_mask(input logic [2:0] code);
        logic [2:0] m;
        m = 3'h0;
        if (!code[2]) begin
            m = (code[1:0] == 2'h3) ? 3'h0 : 3'(3'h1 << code[1:0]);
        end else begin
            unique case (code[1:0])
                2'h0: m = 3'h3;
                2'h1: m = 3'h5;
                2'h2: m = 3'h6;
                2'h3: m = 3'h7;
            endcase
        end
        return m;
    endfunction

    logic [31:0] table_write_word_lo;
    logic [31:0] table_write_word_hi;
    logic [31:0] table_read_word_lo;
    logic [31:0] table_read_word_hi;
    logic [1:0]  table_command_reg;
    logic        dest_addr_top_priority;
    logic [AW-1:0] rptr;
    logic        rd_ok;
    mtab_state_t state;
    mtab_state_t next_state;
    mtab_entry_t rdata;
    mtab_entry_t wentry;
    logic [31:0] load_hi;
    logic [AW-1:0] mem_raddr_q;
    logic [AW:0] scan_cycles;

    wire sel_cmd   = reg_addr == `MTAB_IDX_CMD;
    wire sel_wr_lo = reg_addr == `MTAB_IDX_WR_LO;
    wire sel_wr_hi = reg_addr == `MTAB_IDX_WR_HI;
    wire sel_rd_lo = reg_addr == `MTAB_IDX_RD_LO;
    wire sel_rd_hi = reg_addr == `MTAB_IDX_RD_HI;
    wire sel_gcfg  = reg_addr == `MTAB_IDX_GCFG;
    wire wr_cmd    = reg_wr && sel_cmd;
    wire go_first  = wr_cmd && reg_wdata[`MTAB_CMD_FIRST];
    wire go_next   = wr_cmd && reg_wdata[`MTAB_CMD_NEXT] && !go_first;
    wire go        = go_first || go_next;
    wire at_top    = rptr == AW'(DEPTH - 1);
    wire found     = state == MTAB_SCAN && rd_ok && rdata.valid;
    wire hit_end   = state == MTAB_SCAN && rd_ok && at_top;
    // step moves the pointer and the memory address together, so read data match rptr
    wire step      = state == MTAB_SCAN && rd_ok && !found && !hit_end;
    wire [AW-1:0] scan_addr = go_first ? '0 : ((go || step) ? rptr + AW'(1) : rptr);
    wire [AW-1:0] mem_raddr = (walk_busy || go) ? scan_addr : look_addr;

    assign walk_busy = state != MTAB_IDLE;

    always_comb begin
        next_state = state;
        unique case (state)
            MTAB_IDLE: if (go) next_state = MTAB_SCAN;
            MTAB_SCAN: if (found || hit_end) next_state = MTAB_DONE;
            MTAB_DONE: next_state = MTAB_IDLE;
        endcase
        if (go) next_state = MTAB_SCAN;
    end

    // entry built from the two write staging words
    always_comb begin
        wentry          = '0;
        wentry.mac      = {table_write_word_hi[15:0], table_write_word_lo};
        wentry.valid    = table_write_word_hi[`MTAB_BIT_VALID];
        wentry.age      = table_write_word_hi[`MTAB_BIT_END];
        wentry.static_e = table_write_word_hi[`MTAB_BIT_STATIC];
        wentry.filter   = table_write_word_hi[`MTAB_BIT_FILTER];
        wentry.pri_en   = table_write_word_hi[`MTAB_BIT_PRIEN];
        wentry.pri      = table_write_word_hi[`MTAB_PRI_LSB +: 3];
        wentry.port     = table_write_word_hi[`MTAB_PORT_MSB:`MTAB_PORT_LSB];
    end

    mtab_mem #(.DEPTH(DEPTH), .AW(AW)) u_mem (
        .clk   (clk),
        .we    (make_entry),
        .waddr (make_addr),
        .wdata (wentry),
        .raddr (mem_raddr),
        .rdata (rdata)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state <= MTAB_IDLE;
            rptr  <= '0;
            rd_ok <= 1'b0;
        end else begin
            state <= next_state;
            rd_ok <= go || step;
            if (go || step) begin
                rptr <= scan_addr;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            table_write_word_lo    <= `MTAB_RST_WORD;
            table_write_word_hi    <= `MTAB_RST_WORD;
            table_command_reg      <= 2'h0;
            dest_addr_top_priority <= 1'b0;
        end else if (reg_wr) begin
            if (sel_wr_lo) table_write_word_lo <= reg_wdata;
            if (sel_wr_hi) table_write_word_hi <= reg_wdata & `MTAB_HI_WR_MASK;
            if (sel_cmd) table_command_reg <= reg_wdata[1:0];
            if (sel_gcfg) dest_addr_top_priority <= reg_wdata[0];
        end
    end

    // upper read word as loaded from a found entry
    always_comb begin
        load_hi                                = '0;
        load_hi[15:0]                          = rdata.mac[47:32];
        load_hi[`MTAB_PORT_MSB:`MTAB_PORT_LSB] = rdata.port;
        load_hi[`MTAB_PRI_LSB +: 3]            = rdata.pri;
        load_hi[`MTAB_BIT_PRIEN]               = rdata.pri_en;
        load_hi[`MTAB_BIT_FILTER]              = rdata.filter;
        load_hi[`MTAB_BIT_STATIC]              = rdata.static_e;
        load_hi[`MTAB_BIT_END]                 = at_top;
        load_hi[`MTAB_BIT_VALID]               = 1'b1;
    end

    // read words change only through the walk engine
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            table_read_word_lo <= `MTAB_RST_WORD;
            table_read_word_hi <= `MTAB_RST_WORD;
        end else if (go) begin
            table_read_word_hi[`MTAB_BIT_VALID] <= 1'b0;
            table_read_word_hi[`MTAB_BIT_END]   <= 1'b0;
        end else if (found) begin
            table_read_word_lo <= rdata.mac[31:0];
            table_read_word_hi <= load_hi;
        end else if (hit_end) begin
            table_read_word_hi[`MTAB_BIT_END] <= 1'b1;
        end
    end

    // read mux; reads have no side effect
    wire [31:0] rd_mux =
        sel_rd_lo ? table_read_word_lo :
        sel_rd_hi ? table_read_word_hi :
        sel_wr_lo ? table_write_word_lo :
        sel_wr_hi ? table_write_word_hi :
        sel_cmd   ? {30'h0, table_command_reg} :
        sel_gcfg  ? {31'h0, dest_addr_top_priority} : 32'h0;

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= 32'h0;
        end else begin
            reg_rdata <= reg_rd ? rd_mux : 32'h0;
        end
    end

    // lookup results follow the registered memory read
    always_comb begin
        look_ports   = port_mask(rdata.port);
        look_filter  = rdata.valid && rdata.filter;
        look_pri     = rdata.pri;
        look_pri_use = rdata.valid && rdata.pri_en && dest_addr_top_priority;
    end

    a_valid_clear: assert property (@(posedge clk) disable iff (rst)
        go |=> !table_read_word_hi[`MTAB_BIT_VALID])
        else $error("valid not cleared by fetch");
    a_found_valid: assert property (@(posedge clk) disable iff (rst)
        (found && !go) |=> table_read_word_hi[`MTAB_BIT_VALID])
        else $error("valid not set on found entry");
    a_end_flag: assert property (@(posedge clk) disable iff (rst)
        (hit_end && !go) |=> table_read_word_hi[`MTAB_BIT_END])
        else $error("end flag not set");
    a_load_cause: assert property (@(posedge clk) disable iff (rst)
        !$stable(table_read_word_lo) |-> $past(found))
        else $error("read word changed without fetch");
    a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
        table_read_word_hi[31:27] == 5'h0)
        else $error("reserved bits set");
    a_first_rewind: assert property (@(posedge clk) disable iff (rst)
        go_first |=> rptr == '0)
        else $error("fetch first did not rewind");
    a_pri_gate: assert property (@(posedge clk) disable iff (rst)
        look_pri_use |-> dest_addr_top_priority && rdata.pri_en)
        else $error("priority used without enables");
    a_port_mask: assert property (@(posedge clk) disable iff (rst)
        rdata.port == 3'h3 |-> look_ports == 3'h0)
        else $error("reserved port code selected ports");

    // assertion helpers: address behind the registered read, cycles spent scanning
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            mem_raddr_q <= '0;
            scan_cycles <= '0;
        end else begin
            mem_raddr_q <= mem_raddr;
            if (go || state != MTAB_SCAN) begin
                scan_cycles <= '0;
            end else begin
                scan_cycles <= scan_cycles + 1'b1;
            end
        end
    end

    // walk engine and command register checks

    a_scan_align: assert property (@(posedge clk) disable iff (rst)
        (state == MTAB_SCAN && rd_ok) |-> mem_raddr_q == rptr)
        else $error("scan data not from pointer entry");

    a_scan_bound: assert property (@(posedge clk) disable iff (rst)
        scan_cycles < DEPTH)
        else $error("scan ran past table size");

    a_scan_stop: assert property (@(posedge clk) disable iff (rst)
        ((found || hit_end) && !go) |=> state == MTAB_DONE)
        else $error("scan did not stop");

    a_next_step: assert property (@(posedge clk) disable iff (rst)
        go_next |=> rptr == $past(rptr) + AW'(1))
        else $error("fetch next did not advance");

    a_cmd_store: assert property (@(posedge clk) disable iff (rst)
        wr_cmd |=> table_command_reg == $past(reg_wdata[1:0]))
        else $error("command bits not stored");

    // read word and write staging word checks

    a_hi_hold: assert property (@(posedge clk) disable iff (rst)
        !(go || found || hit_end) |=> $stable(table_read_word_hi))
        else $error("upper read word changed without fetch");

    a_end_clear: assert property (@(posedge clk) disable iff (rst)
        go |=> !table_read_word_hi[`MTAB_BIT_END])
        else $error("end flag not cleared by fetch");

    a_end_top: assert property (@(posedge clk) disable iff (rst)
        (found && !go) |=> table_read_word_hi[`MTAB_BIT_END] == $past(at_top))
        else $error("end flag wrong on found entry");

    a_mac_load: assert property (@(posedge clk) disable iff (rst)
        (found && !go) |=> {table_read_word_hi[15:0], table_read_word_lo} == $past(rdata.mac))
        else $error("address not loaded from entry");

    a_load_fields: assert property (@(posedge clk) disable iff (rst)
        (found && !go) |=>
            table_read_word_hi[`MTAB_BIT_STATIC] == $past(rdata.static_e) &&
            table_read_word_hi[`MTAB_BIT_FILTER] == $past(rdata.filter) &&
            table_read_word_hi[`MTAB_BIT_PRIEN] == $past(rdata.pri_en))
        else $error("entry flags not loaded");

    a_pri_load: assert property (@(posedge clk) disable iff (rst)
        (found && !go) |=> table_read_word_hi[`MTAB_PRI_LSB +: 3] == $past(rdata.pri))
        else $error("priority not loaded");

    a_port_load: assert property (@(posedge clk) disable iff (rst)
        (found && !go) |=>
            table_read_word_hi[`MTAB_PORT_MSB:`MTAB_PORT_LSB] == $past(rdata.port))
        else $error("port code not loaded");

    a_wr_mask: assert property (@(posedge clk) disable iff (rst)
        table_write_word_hi[31:27] == 5'h0)
        else $error("reserved staging bits kept");

    // register port and lookup checks

    a_read_quiet: assert property (@(posedge clk) disable iff (rst)
        (reg_rd && state == MTAB_IDLE) |=> $stable(rptr) && $stable(state))
        else $error("read disturbed the walk engine");

    a_rdata_idle: assert property (@(posedge clk) disable iff (rst)
        !reg_rd |=> reg_rdata == 32'h0)
        else $error("read data without read strobe");

    a_lookup_idle: assert property (@(posedge clk) disable iff (rst)
        (!walk_busy && !go) |=> mem_raddr_q == $past(look_addr))
        else $error("lookup address not used while idle");

    a_port_single: assert property (@(posedge clk) disable iff (rst)
        !rdata.port[2] |-> $countones(look_ports) <= 1)
        else $error("single code selected several ports");

    a_port_multi: assert property (@(posedge clk) disable iff (rst)
        rdata.port[2] |-> $countones(look_ports) >= 2)
        else $error("multiple code selected under two ports");
endmodule

// file: sim/mtab_regs_tb.sv
// self-checking bench for the mac lookup table entry data registers
// assumes mtab_regs built with a 16-entry table; register port driven directly
`timescale 1ns/1ps
`include "mtab_defs.svh"
module mtab_regs_tb;
    logic        clk        = 1'b0;
    logic        rst        = 1'b1;
    logic [15:0] reg_addr   = 16'h0000;
    logic [31:0] reg_wdata  = 32'h00000000;
    logic        reg_wr     = 1'b0;
    logic        reg_rd     = 1'b0;
    logic [31:0] reg_rdata;
    logic        make_entry = 1'b0;
    logic [3:0]  make_addr  = 4'h0;
    logic [3:0]  look_addr  = 4'h0;
    logic [2:0]  look_pri;
    logic        look_pri_use;
    logic        look_filter;
    logic [2:0]  look_ports;
    logic        walk_busy;
    logic [31:0] d;
    int          num_errors  = 0;
    int          checks_done = 0;

    always #2 clk = ~clk;

    mtab_regs #(.DEPTH(16), .AW(4)) i_mtab_regs (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .make_entry(make_entry), .make_addr(make_addr), .look_addr(look_addr),
        .look_pri(look_pri), .look_pri_use(look_pri_use), .look_filter(look_filter),
        .look_ports(look_ports), .walk_busy(walk_busy)
    );

    task automatic summarize;
        $display("errors=%0d checks=%0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] v);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask

    task automatic mk(input logic [3:0] i);
        @(posedge clk);
        make_addr  <= i;
        make_entry <= 1'b1;
        @(posedge clk);
        make_entry <= 1'b0;
    endtask

    task automatic settle;
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask

    function automatic logic [31:0] hw(input logic v, e, s, f, p,
                                       input logic [2:0] pr, pt, input logic [15:0] m);
        return {5'h00, v, e, s, f, p, pr, pt, m};
    endfunction

    // issue a fetch, see valid and end drop, clear the bit, wait for the scan
    task automatic fetch(input logic [31:0] c);
        int n;
        n = 0;
        wr(`MTAB_IDX_CMD, c);
        rd(`MTAB_IDX_RD_HI);
        chk(d[26:25], 2'b00);
        wr(`MTAB_IDX_CMD, 32'h00000000);
        @(negedge clk);
        while (walk_busy !== 1'b0 && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(walk_busy, 1'b0);
    endtask

    task automatic t_reset;
        rd(`MTAB_IDX_RD_LO);
        chk(d, `MTAB_RST_WORD);
        rd(`MTAB_IDX_RD_HI);
        chk(d, 32'h00000000);
        rd(16'h1807);
        chk(d, 32'h00000000);
    endtask

    task automatic t_fill;
        wr(`MTAB_IDX_WR_LO, 32'h00000000);
        wr(`MTAB_IDX_WR_HI, 32'h00000000);
        for (int i = 0; i < 16; i++) begin
            mk(i[3:0]);
        end
        wr(`MTAB_IDX_WR_LO, 32'h456789ab);
        wr(`MTAB_IDX_WR_HI, hw(1, 0, 1, 0, 1, 3'h5, 3'h5, 16'h0123) | 32'hf8000000);
        mk(4'h9);
        wr(`MTAB_IDX_WR_LO, 32'h13579bdf);
        wr(`MTAB_IDX_WR_HI, hw(1, 0, 0, 1, 0, 3'h2, 3'h2, 16'h2468));
        mk(4'hf);
    endtask

    task automatic t_walk;
        fetch(32'h1 << `MTAB_CMD_FIRST);
        rd(`MTAB_IDX_RD_LO);
        chk(d, 32'h456789ab);
        rd(`MTAB_IDX_RD_HI);
        chk(d, hw(1, 0, 1, 0, 1, 3'h5, 3'h5, 16'h0123));
        wr(`MTAB_IDX_RD_LO, 32'hffffffff);
        rd(`MTAB_IDX_RD_LO);
        chk(d, 32'h456789ab);
        fetch(32'h1 << `MTAB_CMD_NEXT);
        rd(`MTAB_IDX_RD_LO);
        chk(d, 32'h13579bdf);
        rd(`MTAB_IDX_RD_HI);
        chk(d, hw(1, 1, 0, 1, 0, 3'h2, 3'h2, 16'h2468));
        wr(`MTAB_IDX_WR_HI, hw(0, 0, 0, 1, 0, 3'h2, 3'h2, 16'h2468));
        mk(4'hf);
        fetch(32'h1 << `MTAB_CMD_FIRST);
        fetch(32'h1 << `MTAB_CMD_NEXT);
        rd(`MTAB_IDX_RD_HI);
        chk(d[26:25], 2'b01);
        rd(`MTAB_IDX_RD_LO);
        chk(d, 32'h456789ab);
    endtask

    task automatic t_look;
        logic [2:0] pm [8] = '{3'h1, 3'h2, 3'h4, 3'h0, 3'h3, 3'h5, 3'h6, 3'h7};
        @(posedge clk);
        look_addr <= 4'h9;
        wr(`MTAB_IDX_GCFG, 32'h00000001);
        settle();
        chk({look_pri_use, look_pri}, 4'hd);
        wr(`MTAB_IDX_GCFG, 32'h00000000);
        settle();
        chk(look_pri_use, 1'b0);
        for (int c = 0; c < 8; c++) begin
            wr(`MTAB_IDX_WR_HI, hw(1, 0, 1, c[0], 1, 3'h5, c[2:0], 16'h0123));
            mk(4'h9);
            settle();
            chk(look_ports, pm[c]);
            chk(look_filter, c[0]);
        end
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        t_reset();
        t_fill();
        t_walk();
        t_look();
        summarize();
    end

    // watchdog sized well beyond the few hundred cycles the tests need
    initial begin
        #100000;
        num_errors++;
        summarize();
    end
endmodule
